/* core/ipr_pkg.sv */
package ipr_pkg;
	// ************************************************************
	// register map, offsets chosen for this block
	// ************************************************************
	localparam logic [31:0] IPR_OFF_FIVE = 32'h0000_0000; // fifth priority register
	localparam logic [31:0] IPR_OFF_SIX = 32'h0000_0004; // sixth priority register
	localparam logic [31:0] IPR_OFF_SEVEN = 32'h0000_0008; // seventh priority register
	localparam int IPR_ADDR_W = 4; // decoded address bits
	localparam int IPR_NREG = 3; // number of registers
	// field layout, same in every register
	localparam int IPR_PRI_W = 3; // priority width
	localparam int IPR_SUB_W = 2; // subpriority width
	localparam int IPR_SLOT_W = 8; // bits per source slot
	localparam int IPR_NSLOT = 4; // sources per register
	localparam int IPR_SUB_LSB = 0; // subpriority low bit in a slot
	localparam int IPR_PRI_LSB = 2; // priority low bit in a slot
	// writable bits: 28-24, 20-16, 12-8, 4-0
	localparam logic [31:0] IPR_WMASK = 32'h1F1F_1F1F;
	localparam logic [31:0] IPR_RESET = 32'h0000_0000; // power-on value
	localparam logic [IPR_PRI_W-1:0] IPR_PRI_OFF = 3'h0; // source disabled
	// register index from byte address bits 3-2
	localparam int IPR_IDX_LSB = 2; // low bit of the index in a byte address
	localparam logic [1:0] IPR_IDX_FIVE = 2'h0; // fifth priority register
	localparam logic [1:0] IPR_IDX_SIX = 2'h1; // sixth priority register
	localparam logic [1:0] IPR_IDX_SEVEN = 2'h2; // seventh priority register
	localparam logic [1:0] IPR_IDX_NONE = 2'h3; // unmapped, reads zero
	// slot numbers inside a register
	localparam int IPR_SLOT_TOP = 3; // bits 28-24
	localparam int IPR_SLOT_HIGH = 2; // bits 20-16
	localparam int IPR_SLOT_LOW = 1; // bits 12-8
	localparam int IPR_SLOT_BOT = 0; // bits 4-0
	// ahb codes
	localparam logic [1:0] IPR_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] IPR_HTRANS_SEQ = 2'h3;
	localparam logic [2:0] IPR_HSIZE_WORD = 3'h2;
	localparam logic [1:0] IPR_IDX_W = 2'h2; // register index width marker
	typedef logic [31:0] ipr_word_t;
endpackage

/* core/ipr_regfile.sv */
`timescale 1ns/100ps
// ************************************************************
// small register store, registered read port
// ************************************************************
module ipr_regfile (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire ipr_pkg::ipr_word_t wr_data,
	input wire logic rd_en,
	input wire logic [1:0] rd_idx,
	output ipr_pkg::ipr_word_t rd_data,
	output ipr_pkg::ipr_word_t reg_five,
	output ipr_pkg::ipr_word_t reg_six,
	output ipr_pkg::ipr_word_t reg_seven
);
	import ipr_pkg::*;
	ipr_word_t mem_q [IPR_NREG]; // stored words, unimplemented bits held zero
	ipr_word_t rd_q; // read data register
	// write path, masked so reserved bits never store
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < IPR_NREG; i++) begin
				mem_q[i] <= IPR_RESET;
			end
		end else if (wr_en && (wr_idx < IPR_NREG)) begin
			mem_q[wr_idx] <= wr_data & IPR_WMASK;
		end
	end
	// read path, zero for unmapped index
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= IPR_RESET;
		end else if (rd_en) begin
			rd_q <= (rd_idx < IPR_NREG) ? mem_q[rd_idx] : IPR_RESET;
		end
	end
	assign rd_data = rd_q;
	assign reg_five = mem_q[IPR_IDX_FIVE];
	assign reg_six = mem_q[IPR_IDX_SIX];
	assign reg_seven = mem_q[IPR_IDX_SEVEN];
endmodule // ipr_regfile

/* core/ipr_top.sv */
`timescale 1ns/100ps
module ipr_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [2:0] serial_periph_a_priority,
	output logic [1:0] serial_periph_a_subpriority,
	output logic serial_periph_a_enabled,
	output logic [2:0] out_compare_e_priority,
	output logic [1:0] out_compare_e_subpriority,
	output logic out_compare_e_enabled,
	output logic [2:0] in_capture_e_priority,
	output logic [1:0] in_capture_e_subpriority,
	output logic in_capture_e_enabled,
	output logic [2:0] timer_e_priority,
	output logic [1:0] timer_e_subpriority,
	output logic timer_e_enabled,
	output logic [2:0] converter_priority,
	output logic [1:0] converter_subpriority,
	output logic converter_enabled,
	output logic [2:0] input_change_priority,
	output logic [1:0] input_change_subpriority,
	output logic input_change_enabled,
	output logic [2:0] two_wire_a_priority,
	output logic [1:0] two_wire_a_subpriority,
	output logic two_wire_a_enabled,
	output logic [2:0] async_serial_a_priority,
	output logic [1:0] async_serial_a_subpriority,
	output logic async_serial_a_enabled,
	output logic [2:0] serial_periph_b_priority,
	output logic [1:0] serial_periph_b_subpriority,
	output logic serial_periph_b_enabled,
	output logic [2:0] comparator_b_priority,
	output logic [1:0] comparator_b_subpriority,
	output logic comparator_b_enabled,
	output logic [2:0] comparator_a_priority,
	output logic [1:0] comparator_a_subpriority,
	output logic comparator_a_enabled,
	output logic [2:0] parallel_port_priority,
	output logic [1:0] parallel_port_subpriority,
	output logic parallel_port_enabled
);
	import ipr_pkg::*;

	// ************************************************************
	// field extraction helpers
	// ************************************************************
	// priority of slot n (0 = bits 4-2, 3 = bits 28-26)
	function automatic logic [IPR_PRI_W-1:0] pri_of(input ipr_word_t w, input int n);
		pri_of = w[n*IPR_SLOT_W+IPR_PRI_LSB +: IPR_PRI_W];
	endfunction
	// subpriority of slot n (0 = bits 1-0, 3 = bits 25-24)
	function automatic logic [IPR_SUB_W-1:0] sub_of(input ipr_word_t w, input int n);
		sub_of = w[n*IPR_SLOT_W+IPR_SUB_LSB +: IPR_SUB_W];
	endfunction
	// register index from a byte address
	function automatic logic [1:0] idx_of(input logic [31:0] a);
		idx_of = a[IPR_ADDR_W-1:IPR_IDX_LSB];
	endfunction
	// enable bit per slot: nonzero priority lets the source request
	function automatic logic [IPR_NSLOT-1:0] en_of(input ipr_word_t w);
		en_of = '0;
		for (int n = 0; n < IPR_NSLOT; n++) begin
			en_of[n] = pri_of(w, n) != IPR_PRI_OFF;
		end
	endfunction

	// ************************************************************
	// ahb-lite slave: address phase capture
	// ************************************************************
	logic wr_pend_q; // write data phase pending
	logic [1:0] wr_idx_q; // index latched for write
	wire xfer_valid; // valid address phase this cycle
	wire [1:0] rd_idx_sel; // read index, unmapped forced to IPR_IDX_NONE, which reads zero
	wire wr_five; // write lands in fifth register this cycle
	wire wr_six; // write lands in sixth register this cycle
	wire wr_seven; // write lands in seventh register this cycle
	ipr_word_t wr_word; // write data as it will be stored
	logic [IPR_NSLOT-1:0] en_five_q; // per-slot enable, fifth register
	logic [IPR_NSLOT-1:0] en_six_q; // per-slot enable, sixth register
	logic [IPR_NSLOT-1:0] en_seven_q; // per-slot enable, seventh register
	wire in_map; // address hits a register
	wire [1:0] a_idx; // decoded index
	wire rd_start; // read accepted
	wire wr_start; // write accepted
	ipr_word_t rd_word; // registered read data
	ipr_word_t w_five; // stored fifth register
	ipr_word_t w_six; // stored sixth register
	ipr_word_t w_seven; // stored seventh register

	assign xfer_valid = hsel && hready && htrans[1];
	assign in_map = (haddr[31:IPR_ADDR_W] == '0) && (idx_of(haddr) < IPR_NREG);
	assign a_idx = idx_of(haddr);
	assign rd_start = xfer_valid && !hwrite;
	assign wr_start = xfer_valid && hwrite;
	assign rd_idx_sel = in_map ? a_idx : IPR_IDX_NONE;

	// latch write target, data arrives next cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= IPR_IDX_FIVE;
		end else begin
			wr_pend_q <= wr_start && in_map;
			wr_idx_q <= a_idx;
		end
	end

	// ************************************************************
	// register store
	// ************************************************************
	ipr_regfile u_store (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(wr_pend_q),
		.wr_idx(wr_idx_q),
		.wr_data(hwdata),
		.rd_en(rd_start),
		.rd_idx(rd_idx_sel),
		.rd_data(rd_word),
		.reg_five(w_five),
		.reg_six(w_six),
		.reg_seven(w_seven)
	);

	// ************************************************************
	// bus answers, every one leaves a flop
	// ************************************************************
	// no wait states and no error answer; flops keep the pins registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1; // ready even while held in reset
			hresp <= 1'b0; // okay
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
	// read register already holds zero for unmapped places
	assign hrdata = rd_word;

	// ************************************************************
	// field outputs to arbitration, straight from the store flops
	// ************************************************************
	always_comb begin
		serial_periph_a_priority = pri_of(w_five, IPR_SLOT_TOP);
		serial_periph_a_subpriority = sub_of(w_five, IPR_SLOT_TOP);
		out_compare_e_priority = pri_of(w_five, IPR_SLOT_HIGH);
		out_compare_e_subpriority = sub_of(w_five, IPR_SLOT_HIGH);
		in_capture_e_priority = pri_of(w_five, IPR_SLOT_LOW);
		in_capture_e_subpriority = sub_of(w_five, IPR_SLOT_LOW);
		timer_e_priority = pri_of(w_five, IPR_SLOT_BOT);
		timer_e_subpriority = sub_of(w_five, IPR_SLOT_BOT);
		converter_priority = pri_of(w_six, IPR_SLOT_TOP);
		converter_subpriority = sub_of(w_six, IPR_SLOT_TOP);
		input_change_priority = pri_of(w_six, IPR_SLOT_HIGH);
		input_change_subpriority = sub_of(w_six, IPR_SLOT_HIGH);
		two_wire_a_priority = pri_of(w_six, IPR_SLOT_LOW);
		two_wire_a_subpriority = sub_of(w_six, IPR_SLOT_LOW);
		async_serial_a_priority = pri_of(w_six, IPR_SLOT_BOT);
		async_serial_a_subpriority = sub_of(w_six, IPR_SLOT_BOT);
		serial_periph_b_priority = pri_of(w_seven, IPR_SLOT_TOP);
		serial_periph_b_subpriority = sub_of(w_seven, IPR_SLOT_TOP);
		comparator_b_priority = pri_of(w_seven, IPR_SLOT_HIGH);
		comparator_b_subpriority = sub_of(w_seven, IPR_SLOT_HIGH);
		comparator_a_priority = pri_of(w_seven, IPR_SLOT_LOW);
		comparator_a_subpriority = sub_of(w_seven, IPR_SLOT_LOW);
		parallel_port_priority = pri_of(w_seven, IPR_SLOT_BOT);
		parallel_port_subpriority = sub_of(w_seven, IPR_SLOT_BOT);
	end
	// levels pass unchanged: value is the level

	// ************************************************************
	// enable flags, loaded on the edge that stores the field
	// ************************************************************
	// same masked word the store takes, so flag and field agree
	assign wr_word = hwdata & IPR_WMASK;
	assign wr_five = wr_pend_q && (wr_idx_q == IPR_IDX_FIVE);
	assign wr_six = wr_pend_q && (wr_idx_q == IPR_IDX_SIX);
	assign wr_seven = wr_pend_q && (wr_idx_q == IPR_IDX_SEVEN);

	// one flop per source, so the flag never lags its priority field
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_five_q <= '0; // every source off after reset
			en_six_q <= '0;
			en_seven_q <= '0;
		end else begin
			if (wr_five) begin
				en_five_q <= en_of(wr_word);
			end
			if (wr_six) begin
				en_six_q <= en_of(wr_word);
			end
			if (wr_seven) begin
				en_seven_q <= en_of(wr_word);
			end
		end
	end

	// zero priority never requests service
	always_comb begin
		serial_periph_a_enabled = en_five_q[IPR_SLOT_TOP];
		out_compare_e_enabled = en_five_q[IPR_SLOT_HIGH];
		in_capture_e_enabled = en_five_q[IPR_SLOT_LOW];
		timer_e_enabled = en_five_q[IPR_SLOT_BOT];
		converter_enabled = en_six_q[IPR_SLOT_TOP];
		input_change_enabled = en_six_q[IPR_SLOT_HIGH];
		two_wire_a_enabled = en_six_q[IPR_SLOT_LOW];
		async_serial_a_enabled = en_six_q[IPR_SLOT_BOT];
		serial_periph_b_enabled = en_seven_q[IPR_SLOT_TOP];
		comparator_b_enabled = en_seven_q[IPR_SLOT_HIGH];
		comparator_a_enabled = en_seven_q[IPR_SLOT_LOW];
		parallel_port_enabled = en_seven_q[IPR_SLOT_BOT];
	end
endmodule // ipr_top

/* sim/ipr_properties.sv */
`timescale 1ns/100ps
// ************************************************************
// bus response and field output checks
// ************************************************************
module ipr_properties (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [2:0] serial_periph_a_priority,
	input wire logic [1:0] serial_periph_a_subpriority,
	input wire logic serial_periph_a_enabled,
	input wire logic [2:0] converter_priority,
	input wire logic [1:0] converter_subpriority,
	input wire logic [2:0] parallel_port_priority,
	input wire logic [1:0] parallel_port_subpriority
);
	logic wr_q; // a write is in its data phase
	logic [1:0] sel_q; // register index of that write, 3 when unmapped
	logic [31:0] wd_q; // data seen at the end of the data phase
	// follow each address phase into its data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			sel_q <= 2'h3;
			wd_q <= 32'h0000_0000;
		end else begin
			wr_q <= hsel && hready && htrans[1] && hwrite;
			sel_q <= (haddr[31:4] == 28'h000_0000) ? haddr[3:2] : 2'h3;
			wd_q <= hwdata;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_ready_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	chk_zero_off: assert property (serial_periph_a_enabled == (serial_periph_a_priority != 3'h0))
		else $error("enable does not follow priority");
	chk_unimp_zero: assert property ((hrdata & 32'hE0E0_E0E0) == 32'h0000_0000)
		else $error("unimplemented bits read nonzero");
	chk_reset_clear: assert property ($rose(hresetn) |-> {serial_periph_a_priority,
		converter_priority, parallel_port_subpriority} == 8'h00)
		else $error("fields not cleared by reset");
	chk_hold_value: assert property (!wr_q |=> $stable({serial_periph_a_priority,
		converter_subpriority, parallel_port_priority}))
		else $error("field changed without a write");
	chk_map_five: assert property (wr_q && sel_q == 2'h0 |=> {serial_periph_a_priority,
		serial_periph_a_subpriority} == wd_q[28:24])
		else $error("fifth register field misplaced");
	chk_map_six: assert property (wr_q && sel_q == 2'h1 |=> {converter_priority,
		converter_subpriority} == wd_q[28:24])
		else $error("sixth register field misplaced");
	chk_map_seven: assert property (wr_q && sel_q == 2'h2 |=> {parallel_port_priority,
		parallel_port_subpriority} == wd_q[4:0])
		else $error("seventh register field misplaced");
endmodule // ipr_properties

bind ipr_top ipr_properties u_chk (.*);

/* sim/tb.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
// ************************************************************
// register access and field output tests
// ************************************************************
module tb;
	import ipr_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = IPR_HSIZE_WORD;
	logic [31:0] hwdata = 32'h0000_0000;
	wire logic hready;
	logic hreadyout, hresp;
	logic [31:0] hrdata;
	logic [2:0] serial_periph_a_priority, out_compare_e_priority, in_capture_e_priority,
		timer_e_priority, converter_priority, input_change_priority, two_wire_a_priority,
		async_serial_a_priority, serial_periph_b_priority, comparator_b_priority,
		comparator_a_priority, parallel_port_priority;
	logic [1:0] serial_periph_a_subpriority, out_compare_e_subpriority, in_capture_e_subpriority,
		timer_e_subpriority, converter_subpriority, input_change_subpriority,
		two_wire_a_subpriority, async_serial_a_subpriority, serial_periph_b_subpriority,
		comparator_b_subpriority, comparator_a_subpriority, parallel_port_subpriority;
	logic serial_periph_a_enabled, out_compare_e_enabled, in_capture_e_enabled, timer_e_enabled,
		converter_enabled, input_change_enabled, two_wire_a_enabled, async_serial_a_enabled,
		serial_periph_b_enabled, comparator_b_enabled, comparator_a_enabled, parallel_port_enabled;
	wire logic [23:0] pv [3]; // per register: priorities, subpriorities, enables
	logic [31:0] offs [3] = '{IPR_OFF_FIVE, IPR_OFF_SIX, IPR_OFF_SEVEN};
	logic [31:0] w, last [3];
	int n_errors = 0, checked = 0, cycles = 0;
	assign hready = hreadyout; // single slave drives the bus ready
	assign pv[0] = {serial_periph_a_priority, out_compare_e_priority, in_capture_e_priority,
		timer_e_priority, serial_periph_a_subpriority, out_compare_e_subpriority,
		in_capture_e_subpriority, timer_e_subpriority, serial_periph_a_enabled,
		out_compare_e_enabled, in_capture_e_enabled, timer_e_enabled};
	assign pv[1] = {converter_priority, input_change_priority, two_wire_a_priority,
		async_serial_a_priority, converter_subpriority, input_change_subpriority,
		two_wire_a_subpriority, async_serial_a_subpriority, converter_enabled,
		input_change_enabled, two_wire_a_enabled, async_serial_a_enabled};
	assign pv[2] = {serial_periph_b_priority, comparator_b_priority, comparator_a_priority,
		parallel_port_priority, serial_periph_b_subpriority, comparator_b_subpriority,
		comparator_a_subpriority, parallel_port_subpriority, serial_periph_b_enabled,
		comparator_b_enabled, comparator_a_enabled, parallel_port_enabled};
	ipr_top uut (.*);
	// 40 MHz clock
	initial begin
		forever #12.5 hclk = ~hclk;
	end
	// one transfer: address phase, then data phase, each held until ready
	task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= IPR_HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(a, 1'b0, 32'h0000_0000, q);
		`CHK("hrdata", e, q)
	endtask
	// priorities and enables expected from a written word
	function automatic logic [23:0] exp_pv(input logic [31:0] d);
		return {d[28:26], d[20:18], d[12:10], d[4:2], d[25:24], d[17:16], d[9:8], d[1:0],
			|d[28:26], |d[20:18], |d[12:10], |d[4:2]};
	endfunction
	task automatic all_zero;
		for (int r = 0; r < 3; r++) begin
			rd(offs[r], 32'h0000_0000);
			`CHK("fields", 24'h00_0000, pv[r])
		end
	endtask
	task finish_test;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 1000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		all_zero();
		// every level in every slot, unimplemented bits written as ones
		for (int r = 0; r < 3; r++) begin
			for (int v = 0; v < 8; v++) begin
				for (int n = 0; n < 4; n++) begin
					w[n*8 +: 8] = {3'h7, 3'(v + n), 2'(v + n)};
				end
				last[r] = w;
				wr(offs[r], w);
				rd(offs[r], w & IPR_WMASK);
				`CHK("fields", exp_pv(w), pv[r])
			end
		end
		// unmapped places take nothing and read zero
		wr(32'h0000_000C, 32'hFFFF_FFFF);
		wr(32'h0000_0010, 32'hFFFF_FFFF);
		rd(32'h0000_000C, 32'h0000_0000);
		rd(32'h0000_0010, 32'h0000_0000);
		for (int r = 0; r < 3; r++) begin
			rd(offs[r], last[r] & IPR_WMASK);
			`CHK("fields", exp_pv(last[r]), pv[r])
		end
		// reset in mid-run clears everything
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		all_zero();
		finish_test();
	end
endmodule // tb
